// [rtl/timer0_pkg.sv]
// shared constants and types for the 8-bit timer with shared prescaler
package timer0_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [4:0] OFF_CONTROL_A = 5'h00;
  localparam logic [4:0] OFF_CONTROL_B = 5'h04;
  localparam logic [4:0] OFF_COUNT     = 5'h08;
  localparam logic [4:0] OFF_COMPARE_A = 5'h0C;
  localparam logic [4:0] OFF_COMPARE_B = 5'h10;
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h14;
  localparam logic [4:0] OFF_IRQ_FLAGS = 5'h18;
  localparam logic [4:0] OFF_PRESCALER = 5'h1C;

  // control B field positions
  localparam int POS_FORCE_A   = 7;
  localparam int POS_FORCE_B   = 6;
  localparam int POS_WAVE_HIGH = 3;
  // control A field positions (own layout), plus the prescaler reset bit
  localparam int POS_OUT_MODE_A = 6;
  localparam int POS_OUT_MODE_B = 4;
  localparam int POS_PSC_RESET  = 0;

  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_BITS3 = 3'h0;
  localparam logic [9:0] RST_PSC   = 10'h000;

  // count limits
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  // clock select encodings
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIRECT  = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // waveform modes
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_FF    = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_FF  = 3'h3;
  localparam logic [2:0] MODE_PC_CMP   = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;

  // output mode encodings
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } irq_bits_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS  = 2'b10
  } bus_state_e;
endpackage : timer0_pkg

// [rtl/timer0_ctrl_irq_prescaler.sv]
// 8-bit timer/counter: control, compare, flags, shared prescaler, avalon slave
// How it works
// - force bit in non-PWM mode applies compare action to that waveform output now.
// - forced compare sets no flag and never clears the counter.
// - force bits are strobes and always read back zero.
// - reserved control B bits 5:4 and mask/flag bits 7..3 read zero.
// - select 0 stops, 1 direct, 2..5 divide by 8, 64, 256, 1024.
// - select 6 counts falling, 7 rising pin edges, one pulse per edge.
// - external pin counts even when the pin is driven as an output.
// - writing the counter blocks the compare match on the next timer tick.
// - both compare registers are compared with the counter continuously.
// - interrupt request needs global enable, mask bit and flag together.
// - compare flags set when the counter matches their compare register.
// - flags clear on vector execution or a written one; zero does nothing.
// - overflow flag sets on overflow, point depends on waveform mode.
// - one prescaler shared with the wide timer, separate clock selects.
// - select 1 counts on every system clock.
// - prescaler runs free, first count 1 to N clocks after enable.
// - prescaler reset restarts divided phase for every attached timer.
// - count pin sampled, synchronised, edge detected; 2 to 3 cycles latency.
// - external edges bypass the prescaler.
// - wave high bit plus two low bits form the 3-bit waveform mode.
// - non-PWM output modes: off, toggle, clear, set on match.
module timer0_ctrl_irq_prescaler (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EXT_COUNT_PIN,
  input  wire logic        GLOBAL_IRQ_EN,
  input  wire logic [2:0]  VECTOR_DONE,
  output logic      [2:0]  IRQ_REQ,
  output logic             WAVE_OUT_A,
  output logic             WAVE_OUT_B,
  output logic      [3:0]  WIDE_TIMER_TAPS
);
  import timer0_pkg::*;

  bus_state_e  bus_r;
  bus_state_e  bus_nxt;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [7:0]  ctrl_a_r;
  logic [3:0]  ctrl_b_r;
  logic [7:0]  count_r;
  logic [7:0]  count_nxt;
  logic [7:0]  cmp_a_r;
  logic [7:0]  cmp_b_r;
  irq_bits_s   mask_r;
  irq_bits_s   flags_r;
  irq_bits_s   flags_nxt;
  irq_bits_s   flag_set;
  irq_bits_s   flag_clr;
  logic [2:0]  irq_r;
  logic        block_r;
  logic        down_r;
  logic        down_nxt;
  logic        wave_a_r;
  logic        wave_b_r;
  logic [9:0]  psc_r;
  logic [3:0]  taps_r;
  logic        sync1_r;
  logic        sync2_r;
  logic        prev_r;

  // bus decode
  wire         req      = AVS_READ | AVS_WRITE;
  wire         commit   = (bus_r == BUS_ANS) & req;
  wire         wr_lane0 = commit & AVS_WRITE & AVS_BYTEENABLE[0];
  wire [7:0]   wd       = AVS_WRITEDATA[7:0];
  wire         wr_ctl_a = wr_lane0 & (AVS_ADDRESS == OFF_CONTROL_A);
  wire         wr_ctl_b = wr_lane0 & (AVS_ADDRESS == OFF_CONTROL_B);
  wire         wr_count = wr_lane0 & (AVS_ADDRESS == OFF_COUNT);
  wire         wr_cmp_a = wr_lane0 & (AVS_ADDRESS == OFF_COMPARE_A);
  wire         wr_cmp_b = wr_lane0 & (AVS_ADDRESS == OFF_COMPARE_B);
  wire         wr_mask  = wr_lane0 & (AVS_ADDRESS == OFF_IRQ_MASK);
  wire         wr_flags = wr_lane0 & (AVS_ADDRESS == OFF_IRQ_FLAGS);
  wire         wr_psc   = wr_lane0 & (AVS_ADDRESS == OFF_PRESCALER);

  // mode and fields
  wire [2:0]   mode     = {ctrl_b_r[POS_WAVE_HIGH], ctrl_a_r[1:0]};
  wire [2:0]   cs       = ctrl_b_r[2:0];
  wire [1:0]   om_a     = ctrl_a_r[POS_OUT_MODE_A +: 2];
  wire [1:0]   om_b     = ctrl_a_r[POS_OUT_MODE_B +: 2];
  wire         pwm      = mode[0];
  wire         phase_c  = (mode == MODE_PC_FF) | (mode == MODE_PC_CMP);
  wire         top_cmp  = (mode == MODE_CTC) | (mode == MODE_PC_CMP) | (mode == MODE_FAST_CMP);
  wire [7:0]   top      = top_cmp ? cmp_a_r : CNT_MAX;
  wire         at_top   = (count_r == top);

  // prescaler taps; free running, not gated by any select
  wire         tap8     = &psc_r[2:0];
  wire         tap64    = &psc_r[5:0];
  wire         tap256   = &psc_r[7:0];
  wire         tap1024  = &psc_r[9:0];

  // external pin edges taken after the second sync stage only
  wire         ext_rise = sync2_r & ~prev_r;
  wire         ext_fall = ~sync2_r & prev_r;

  logic        tick;
  always_comb begin
    case (cs)
      CS_STOP:     tick = 1'b0;
      CS_DIRECT:   tick = 1'b1;
      CS_DIV8:     tick = tap8;
      CS_DIV64:    tick = tap64;
      CS_DIV256:   tick = tap256;
      CS_DIV1024:  tick = tap1024;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  // compare on each tick, blocked once after a counter write
  wire         eq_a     = (count_r == cmp_a_r);
  wire         eq_b     = (count_r == cmp_b_r);
  wire         match_a  = tick & eq_a & ~block_r;
  wire         match_b  = tick & eq_b & ~block_r;
  wire         force_a  = wr_ctl_b & wd[POS_FORCE_A] & ~pwm;
  wire         force_b  = wr_ctl_b & wd[POS_FORCE_B] & ~pwm;

  // overflow point per mode
  logic        ovf_ev;
  always_comb begin
    case (mode)
      MODE_PC_FF, MODE_PC_CMP: ovf_ev = tick & down_r & (count_r == CNT_ONE);
      MODE_FAST_CMP:           ovf_ev = tick & at_top;
      default:                 ovf_ev = tick & (count_r == CNT_MAX);
    endcase
  end

  // counting sequence
  always_comb begin
    count_nxt = count_r;
    down_nxt  = down_r;
    if (wr_count) begin
      count_nxt = wd;
    end else if (tick) begin
      if (phase_c) begin
        if (!down_r && at_top) begin
          down_nxt  = 1'b1;
          count_nxt = count_r - CNT_ONE;
        end else if (down_r && count_r == CNT_ONE) begin
          down_nxt  = 1'b0;
          count_nxt = CNT_BOTTOM;
        end else if (down_r) begin
          count_nxt = count_r - CNT_ONE;
        end else begin
          count_nxt = count_r + CNT_ONE;
        end
      end else if (at_top) begin
        count_nxt = CNT_BOTTOM; // forced strobes never reach here
        down_nxt  = 1'b0;
      end else begin
        count_nxt = count_r + CNT_ONE;
        down_nxt  = 1'b0;
      end
    end
  end

  // output action for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic hit,
                                     input logic is_pwm, input logic is_pc, input logic dn,
                                     input logic top_hit, input logic tog_ok);
    logic v;
    v = cur;
    if (!is_pwm) begin
      if (hit) begin
        case (om)
          OM_TOGGLE: v = ~cur;
          OM_CLEAR:  v = 1'b0;
          OM_SET:    v = 1'b1;
          default:   v = cur;
        endcase
      end
    end else if (om == OM_TOGGLE) begin
      if (hit && tog_ok) v = ~cur;
    end else if (om[1]) begin
      if (is_pc && hit) v = om[0] ^ dn;
      else if (!is_pc && top_hit) v = ~om[0];
      else if (!is_pc && hit) v = om[0];
    end
    return v;
  endfunction : wave_next

  wire         top_tick = tick & at_top & pwm & ~phase_c;
  wire         wave_a_nxt = wave_next(wave_a_r, om_a, match_a | force_a, pwm, phase_c, down_r,
                                      top_tick, ctrl_b_r[POS_WAVE_HIGH]);
  wire         wave_b_nxt = wave_next(wave_b_r, om_b, match_b | force_b, pwm, phase_c, down_r,
                                      top_tick, 1'b0);

  // flags: set wins over clear
  assign flag_set  = '{cmp_b: match_b, cmp_a: match_a, ovf: ovf_ev};
  assign flag_clr  = wr_flags ? irq_bits_s'(wd[2:0] | VECTOR_DONE) : irq_bits_s'(VECTOR_DONE);
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  // read mux
  logic [7:0]  rd_byte;
  always_comb begin
    case (AVS_ADDRESS)
      OFF_CONTROL_A: rd_byte = ctrl_a_r;
      OFF_CONTROL_B: rd_byte = {4'h0, ctrl_b_r};
      OFF_COUNT:     rd_byte = count_r;
      OFF_COMPARE_A: rd_byte = cmp_a_r;
      OFF_COMPARE_B: rd_byte = cmp_b_r;
      OFF_IRQ_MASK:  rd_byte = {5'h00, mask_r};
      OFF_IRQ_FLAGS: rd_byte = {5'h00, flags_r};
      default:       rd_byte = 8'h00;
    endcase
  end

  assign bus_nxt = (bus_r == BUS_IDLE && req) ? BUS_ANS : BUS_IDLE;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      bus_r   <= BUS_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r   <= bus_nxt;
      wait_r  <= (bus_nxt != BUS_ANS);
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_a_r <= RST_BYTE;
      ctrl_b_r <= 4'h0;
      cmp_a_r  <= RST_BYTE;
      cmp_b_r  <= RST_BYTE;
      mask_r   <= RST_BITS3;
    end else begin
      if (wr_ctl_a) ctrl_a_r <= {wd[7:4], 2'h0, wd[1:0]};
      if (wr_ctl_b) ctrl_b_r <= wd[3:0]; // force bits not stored
      if (wr_cmp_a) cmp_a_r <= wd;
      if (wr_cmp_b) cmp_b_r <= wd;
      if (wr_mask) mask_r <= irq_bits_s'(wd[2:0]);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      count_r  <= RST_BYTE;
      down_r   <= 1'b0;
      block_r  <= 1'b0;
      flags_r  <= RST_BITS3;
      irq_r    <= RST_BITS3;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      down_r   <= down_nxt;
      block_r  <= wr_count | (block_r & ~tick);
      flags_r  <= flags_nxt;
      irq_r    <= {3{GLOBAL_IRQ_EN}} & mask_r & flags_r;
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
    end
  end

  // prescaler; one reset hits both timers' phase
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      psc_r  <= RST_PSC;
      taps_r <= 4'h0;
    end else begin
      psc_r  <= (wr_psc & wd[POS_PSC_RESET]) ? RST_PSC : psc_r + 10'h001;
      taps_r <= {tap1024, tap256, tap64, tap8};
    end
  end

  // pin sampled regardless of its direction
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= EXT_COUNT_PIN;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign IRQ_REQ         = irq_r;
  assign WAVE_OUT_A      = wave_a_r;
  assign WAVE_OUT_B      = wave_b_r;
  assign WIDE_TIMER_TAPS = taps_r;

  a_force_toggle: assert property (@(posedge MCLK) disable iff (!RST_N)
    (force_a && om_a == OM_TOGGLE && !match_a) |=> (wave_a_r != $past(wave_a_r)))
    else $error("forced compare did not toggle output a");
  a_force_no_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    (force_a && !match_a && !flags_r.cmp_a) |=> !flags_r.cmp_a)
    else $error("forced compare raised a flag");
  a_ctrl_b_zeros: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && AVS_READ && AVS_ADDRESS == OFF_CONTROL_B) |-> (AVS_READDATA[7:4] == 4'h0))
    else $error("force or reserved bits read nonzero");
  a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && AVS_READ && (AVS_ADDRESS == OFF_IRQ_MASK || AVS_ADDRESS == OFF_IRQ_FLAGS))
    |-> (AVS_READDATA[7:3] == 5'h00))
    else $error("reserved irq bits read nonzero");
  a_stop_holds: assert property (@(posedge MCLK) disable iff (!RST_N)
    (cs == CS_STOP && !wr_count) |=> (count_r == $past(count_r)))
    else $error("stopped counter moved");
  a_div8_phase: assert property (@(posedge MCLK) disable iff (!RST_N)
    (cs == CS_DIV8 && tick) |-> (psc_r[2:0] == 3'h7))
    else $error("div 8 tick out of phase");
  a_ext_latency: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($rose(EXT_COUNT_PIN) && cs == CS_EXT_RISE && !wr_ctl_b) |-> ##2 (tick || cs != CS_EXT_RISE))
    else $error("rising pin edge not counted after two cycles");
  a_write_blocks: assert property (@(posedge MCLK) disable iff (!RST_N)
    (block_r && tick) |-> (!flag_set.cmp_a && !flag_set.cmp_b))
    else $error("compare match after counter write");
  a_irq_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 (IRQ_REQ == ($past({3{GLOBAL_IRQ_EN}}) & $past(mask_r) & $past(flags_r))))
    else $error("irq request not gated by enable mask flag");
  a_flag_w1c: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_flags && wd[0] && !ovf_ev) |=> !flags_r.ovf)
    else $error("overflow flag not cleared by written one");
  a_psc_restart: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_psc && wd[POS_PSC_RESET]) |=> (psc_r == RST_PSC))
    else $error("prescaler not restarted");
  a_bus_answer: assert property (@(posedge MCLK) disable iff (!RST_N)
    (req && wait_r && bus_r == BUS_IDLE) |=> !AVS_WAITREQUEST)
    else $error("bus answer late");

  c_force: cover property (@(posedge MCLK) disable iff (!RST_N) force_a);
  c_ovf: cover property (@(posedge MCLK) disable iff (!RST_N) ovf_ev);
  c_ext_tick: cover property (@(posedge MCLK) disable iff (!RST_N) tick && cs == CS_EXT_FALL);
  c_irq: cover property (@(posedge MCLK) disable iff (!RST_N) IRQ_REQ != 3'h0);
endmodule : timer0_ctrl_irq_prescaler

// [tb/timer0_ctrl_irq_prescaler_tb_top.sv]
// self-checking bench for the 8-bit timer control, flags and prescaler
module timer0_ctrl_irq_prescaler_tb_top;
  import timer0_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [4:0] a;
    logic [3:0] be;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;

  logic        mclk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_pin;
  logic        gie;
  logic [2:0]  vec_done;
  logic [2:0]  irq_req;
  logic        wave_a;
  logic        wave_b;
  logic [3:0]  taps;
  int          failures;
  int          checked;
  logic [7:0]  rd;
  int          n;
  int          divs [4] = '{8, 64, 256, 1024};
  // writes land first, reads after; be 0 and an unaligned hole are refused
  row_s        rows [11] = '{
    '{OFF_CONTROL_B, 4'h1, 8'hFF, 8'h0F}, '{OFF_CONTROL_B, 4'h1, 8'h00, 8'h00},
    '{OFF_IRQ_MASK, 4'h1, 8'hFF, 8'h07},  '{OFF_COMPARE_A, 4'h1, 8'h5A, 8'h5A},
    '{OFF_COMPARE_A, 4'h0, 8'h77, 8'h5A}, '{OFF_COMPARE_B, 4'h1, 8'hA5, 8'hA5},
    '{OFF_COUNT, 4'h1, 8'h3C, 8'h3C},     '{5'h02, 4'h1, 8'hFF, 8'h00},
    '{OFF_PRESCALER, 4'h1, 8'h01, 8'h00}, '{OFF_IRQ_FLAGS, 4'h1, 8'hFF, 8'h00},
    '{OFF_CONTROL_A, 4'h1, 8'h00, 8'h00}};

  timer0_ctrl_irq_prescaler dut (
    .MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .EXT_COUNT_PIN(ext_pin),
    .GLOBAL_IRQ_EN(gie), .VECTOR_DONE(vec_done), .IRQ_REQ(irq_req), .WAVE_OUT_A(wave_a),
    .WAVE_OUT_B(wave_b), .WIDE_TIMER_TAPS(taps));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic timed_out;
    failures++;
    $display("BAD t=%0t got=%h exp=%h wait ran out", $time, 32'h0, 32'h1);
    tally_and_finish();
  endtask : timed_out

  // request held until waitrequest is seen low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    int k;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) timed_out();
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'h1, q);
    chk({24'h000000, q}, {24'h000000, e});
  endtask : rchk

  // cycles until the sampled condition bit goes high
  task automatic wait_hi(input int which, input int b, output int k);
    logic v;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
      v = (which == 0) ? irq_req[b] : taps[b];
    end while (v !== 1'b1 && k < 3000);
    if (k >= 3000) timed_out();
  endtask : wait_hi

  initial begin
    rst_n = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h1; ext_pin = 1'b0; gie = 1'b0; vec_done = 3'h0;
    failures = 0; checked = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk({irq_req, wave_a, wave_b, avs_waitrequest}, 32'h1);
    rchk(OFF_CONTROL_B, 8'h00);
    rchk(OFF_IRQ_MASK, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be, rd);
      rchk(rows[i].a, rows[i].e);
    end
    rchk(OFF_COUNT, 8'h3C);
    // forced compares, stopped counter, normal mode
    wr(OFF_CONTROL_A, 8'h70);
    wr(OFF_CONTROL_B, 8'h80);
    @(negedge mclk);
    chk({wave_a, wave_b}, 32'h2);
    wr(OFF_CONTROL_B, 8'h40);
    @(negedge mclk);
    chk({wave_a, wave_b}, 32'h3);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    rchk(OFF_COUNT, 8'h3C);
    // fast pwm: force ignored
    wr(OFF_CONTROL_A, 8'h43);
    wr(OFF_CONTROL_B, 8'h80);
    @(negedge mclk);
    chk({wave_a, wave_b}, 32'h3);
    wr(OFF_CONTROL_A, 8'h00);
    // compare a match, direct clock
    wr(OFF_COUNT, 8'h10);
    wr(OFF_COMPARE_A, 8'h14);
    wr(OFF_COMPARE_B, 8'h99);
    wr(OFF_IRQ_MASK, 8'h02);
    gie <= 1'b1;
    wr(OFF_CONTROL_B, CS_DIRECT);
    wait_hi(0, 1, n);
    chk({31'h0, n >= 4 && n <= 8}, 32'h1);
    wr(OFF_CONTROL_B, CS_STOP);
    chk({29'h0, irq_req}, 32'h2);
    wr(OFF_IRQ_FLAGS, 8'h00);
    rchk(OFF_IRQ_FLAGS, 8'h02);
    gie <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({29'h0, irq_req}, 32'h0);
    vec_done <= 3'h2;
    @(posedge mclk);
    vec_done <= 3'h0;
    rchk(OFF_IRQ_FLAGS, 8'h00);
    // counter write blocks the next match
    wr(OFF_COUNT, 8'h80);
    wr(OFF_CONTROL_B, CS_DIRECT);
    wr(OFF_COUNT, 8'h14);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    // overflow at the top of the count
    gie <= 1'b1;
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_COUNT, 8'hFD);
    wait_hi(0, 0, n);
    chk({31'h0, n <= 8}, 32'h1);
    wr(OFF_CONTROL_B, CS_STOP);
    wr(OFF_IRQ_FLAGS, 8'h07);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    // compare b match, direct clock; a and overflow stay out of reach
    wr(OFF_IRQ_MASK, 8'h04);
    wr(OFF_COUNT, 8'h95);
    wr(OFF_CONTROL_B, CS_DIRECT);
    wait_hi(0, 2, n);
    chk({31'h0, n >= 4 && n <= 8}, 32'h1);
    wr(OFF_CONTROL_B, CS_STOP);
    chk({29'h0, irq_req}, 32'h4);
    wr(OFF_IRQ_FLAGS, 8'h07);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    // prescaler taps and divided counting
    for (int i = 0; i < 4; i++) begin
      wait_hi(1, i, n);
      wait_hi(1, i, n);
      chk(n, divs[i]);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CONTROL_B, CS_DIV8 + 3'(i));
      repeat (4 * divs[i]) @(posedge mclk);
      wr(OFF_CONTROL_B, CS_STOP);
      bus(1'b0, OFF_COUNT, 8'h00, 4'h1, rd);
      chk({31'h0, rd >= 8'h03 && rd <= 8'h05}, 32'h1);
    end
    // prescaler reset restarts the phase
    wait_hi(1, 1, n);
    repeat (20) @(posedge mclk);
    wr(OFF_PRESCALER, 8'h01);
    wait_hi(1, 1, n);
    chk({31'h0, n >= 63 && n <= 66}, 32'h1);
    // external edges, rising then falling; pin held stable around enable
    for (int m = 0; m < 2; m++) begin
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CONTROL_B, m == 0 ? CS_EXT_RISE : CS_EXT_FALL);
      repeat (4) begin
        ext_pin <= 1'b1;
        repeat (3) @(posedge mclk);
        ext_pin <= 1'b0;
        repeat (3) @(posedge mclk);
      end
      repeat (5) @(posedge mclk);
      wr(OFF_CONTROL_B, CS_STOP);
      rchk(OFF_COUNT, 8'h04);
    end
    // reset in mid-run: outputs and registers back to idle
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk({irq_req, wave_a, wave_b, avs_waitrequest}, 32'h1);
    rchk(OFF_COUNT, 8'h00);
    rchk(OFF_CONTROL_B, 8'h00);
    tally_and_finish();
  end
endmodule : timer0_ctrl_irq_prescaler_tb_top
